/* ebc_external_bus_ctrl.v */
`timescale 1ns/1ps
`default_nettype none
`include "ebc_map.vh"
// Function
// (R1) Single-chip mode or four external modes
// (R2) Address width 16/18/20/22, 8/16 data
// (R3) Demux: address on address port, data separately
// (R4) Mux: data port carries address then data
// (R5) Cycle, tristate, ALE, RW delay programmable
// (R6) Four windows, select plus config pairs
// (R7) Window 4 beats 3, 2 beats 1
// (R8) Outside windows use default config
// (R9) Four chip selects: three windows plus default
// (R10) Unlatched bit gives combinational chip selects; here cs_n is registered from the decode while idle
// (R11) 1M/256K/64K space: four/two/no segment lines
// (R12) 4 Mbyte space drives six segment lines
// (R13) CAN on segment port limits to A19..A16
// (R14) Up to 4 Mbytes external space
// (R15) Partner latches address on ALE strobe
module ebc_external_bus_ctrl (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   input wire clk_en,
   // Configuration
   input wire [2:0] global_mode,
   input wire [1:0] addr_width,
   input wire chip_select_unlatched_cfg,
   input wire can_on_segment_port,
   input wire [15:0] default_bus_config,
   input wire [63:0] window_bus_config,
   input wire [63:0] window_address_select,
   // Internal access request
   input wire req_valid,
   input wire req_write,
   input wire req_byte,
   input wire [21:0] req_addr,
   input wire [15:0] req_wdata,
   output reg req_ready,
   output reg rsp_valid,
   output reg [15:0] rsp_rdata,
   // External pins
   output reg [15:0] demux_address_port,
   output reg [5:0] segment_address,
   output reg [5:0] segment_address_oe,
   output reg [15:0] shared_data_port_out,
   output reg [15:0] shared_data_port_oe,
   input wire [15:0] shared_data_port_in,
   output reg ale,
   output reg rd_n,
   output reg wr_n,
   output reg [3:0] cs_n,
   output reg busy
);
   // =====================================================================
   // States
   localparam ST_IDLE = 3'h0;
   localparam ST_ALE = 3'h1;
   localparam ST_TRI = 3'h2;
   localparam ST_DLY = 3'h3;
   localparam ST_ACC = 3'h4;
   localparam ST_END = 3'h5;

   reg [2:0] state;
   reg [3:0] cnt;
   reg [15:0] cfg;
   reg [15:0] wdata;
   reg write;
   reg [3:0] cs_lat;
   wire [3:0] hit;
   reg [15:0] sel_cfg;
   reg [3:0] sel_cs;
   reg [5:0] seg_oe;
   wire [2:0] cur_mode;
   wire is_mux;
   wire is_d8;

   // =====================================================================
   // Window decode
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : win
         ebc_window_match u_match (
            .enable(window_bus_config[16*g+`EBC_CFG_EN_BIT]),
            .window_address_select(window_address_select[16*g+15:16*g]),
            .addr(req_addr),
            .hit(hit[g])
         ); // [R6]
      end
   endgenerate

   always @* begin
      // Priority: 4 over 3, 2 over 1, else default
      if (hit[3]) begin
         sel_cfg = window_bus_config[63:48];
         sel_cs = 4'h8;
      end else if (hit[2]) begin
         sel_cfg = window_bus_config[47:32];
         sel_cs = 4'h4;
      end else if (hit[1]) begin
         sel_cfg = window_bus_config[31:16];
         sel_cs = 4'h2;
      end else if (hit[0]) begin
         sel_cfg = window_bus_config[15:0];
         sel_cs = 4'h0;
      end else begin
         sel_cfg = default_bus_config; // [R8]
         sel_cs = 4'h1;
      end // [R7]
      // Window 1 has no chip select; windows 2..4 and default do [R9]
   end

   always @* begin
      case (addr_width)
         `EBC_AW_16: begin
            seg_oe = 6'h00;
         end
         `EBC_AW_18: begin
            seg_oe = 6'h03;
         end
         `EBC_AW_20: begin
            seg_oe = 6'h0f;
         end
         default: begin
            seg_oe = 6'h3f; // [R12] [R14]
         end
      endcase // [R2] [R11]
      if (can_on_segment_port) begin
         seg_oe = seg_oe & 6'h0f; // [R13]
      end
   end

   assign cur_mode = cfg[`EBC_CFG_MODE_HI:`EBC_CFG_MODE_LO];
   assign is_mux = (cur_mode == `EBC_MODE_D16_MUX) ||
      (cur_mode == `EBC_MODE_D8_MUX);
   assign is_d8 = (cur_mode == `EBC_MODE_D8_MUX) ||
      (cur_mode == `EBC_MODE_D8_DEMUX);

   // =====================================================================
   // Bus cycle sequencer
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         cfg <= `EBC_DEFAULT_CFG_RST;
         wdata <= 16'h0000;
         write <= 1'b0;
         cs_lat <= 4'h0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= 16'h0000;
         demux_address_port <= 16'h0000;
         segment_address <= 6'h00;
         segment_address_oe <= 6'h00;
         shared_data_port_out <= 16'h0000;
         shared_data_port_oe <= 16'h0000;
         ale <= 1'b0;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         cs_n <= 4'hf;
         busy <= 1'b0;
      end else if (clk_en) begin
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         segment_address_oe <= (global_mode == `EBC_MODE_SINGLE) ?
            6'h00 : seg_oe;
         if (chip_select_unlatched_cfg && state == ST_IDLE) begin
            cs_n <= (global_mode == `EBC_MODE_SINGLE) ? 4'hf :
               ~sel_cs; // [R10]
         end
         case (state)
            ST_IDLE: begin
               busy <= 1'b0;
               if (!chip_select_unlatched_cfg) begin
                  cs_n <= 4'hf;
               end
               if (req_valid && !req_ready &&
                  global_mode != `EBC_MODE_SINGLE) begin
                  // Single-chip mode never starts a cycle [R1]
                  cfg <= sel_cfg;
                  wdata <= req_byte ? {8'h00, req_wdata[7:0]} : req_wdata;
                  write <= req_write;
                  cs_lat <= sel_cs;
                  busy <= 1'b1;
                  demux_address_port <= req_addr[15:0]; // [R3]
                  segment_address <= req_addr[21:16] & seg_oe;
                  ale <= 1'b1;
                  cnt <= `EBC_ALE_BASE + {3'h0, sel_cfg[`EBC_CFG_ALE_BIT]};
                  if (sel_cfg[`EBC_CFG_MODE_HI:`EBC_CFG_MODE_LO] ==
                     `EBC_MODE_D16_MUX || sel_cfg[`EBC_CFG_MODE_HI:
                     `EBC_CFG_MODE_LO] == `EBC_MODE_D8_MUX) begin
                     shared_data_port_out <= req_addr[15:0]; // [R4]
                     shared_data_port_oe <= 16'hffff;
                  end
                  state <= ST_ALE;
               end
            end
            ST_ALE: begin
               if (!chip_select_unlatched_cfg) begin
                  cs_n <= ~cs_lat;
               end
               if (cnt <= 4'h1) begin
                  ale <= 1'b0; // [R15]
                  cnt <= `EBC_TRI_BASE + {3'h0, cfg[`EBC_CFG_TRI_BIT]};
                  state <= ST_TRI;
               end else begin
                  cnt <= cnt - 4'h1; // [R5]
               end
            end
            ST_TRI: begin
               // Address phase ends on shared port after the strobe falls
               if (is_mux) begin
                  shared_data_port_oe <= 16'h0000;
               end
               if (cnt == 4'h0) begin
                  cnt <= {3'h0, cfg[`EBC_CFG_RWD_BIT]};
                  state <= ST_DLY;
               end else begin
                  cnt <= cnt - 4'h1; // [R5]
               end
            end
            ST_DLY: begin
               if (write) begin
                  shared_data_port_out <= wdata;
                  shared_data_port_oe <= is_d8 ? 16'h00ff : 16'hffff;
               end
               if (cnt == 4'h0) begin
                  rd_n <= write;
                  wr_n <= ~write;
                  cnt <= cfg[`EBC_CFG_MCT_HI:`EBC_CFG_MCT_LO];
                  state <= ST_ACC;
               end else begin
                  cnt <= cnt - 4'h1; // [R5]
               end
            end
            ST_ACC: begin
               if (cnt == 4'h0) begin
                  rd_n <= 1'b1;
                  wr_n <= 1'b1;
                  rsp_rdata <= is_d8 ? {8'h00, shared_data_port_in[7:0]} :
                     shared_data_port_in; // [R3]
                  state <= ST_END;
               end else begin
                  cnt <= cnt - 4'h1; // [R5]
               end
            end
            ST_END: begin
               shared_data_port_oe <= 16'h0000;
               rsp_valid <= 1'b1;
               req_ready <= 1'b1;
               if (!chip_select_unlatched_cfg) begin
                  cs_n <= 4'hf;
               end
               state <= ST_IDLE;
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // ebc_external_bus_ctrl
`default_nettype wire

/* ebc_map.vh */
`ifndef EBC_MAP_VH
`define EBC_MAP_VH
// =====================================================================
// Bus modes
`define EBC_MODE_SINGLE 3'h0
`define EBC_MODE_D16_DEMUX 3'h1
`define EBC_MODE_D16_MUX 3'h2
`define EBC_MODE_D8_MUX 3'h3
`define EBC_MODE_D8_DEMUX 3'h4
// Address width codes
`define EBC_AW_16 2'h0
`define EBC_AW_18 2'h1
`define EBC_AW_20 2'h2
`define EBC_AW_22 2'h3
// Bus config field layout (16 bits)
`define EBC_CFG_MODE_LO 0
`define EBC_CFG_MODE_HI 2
`define EBC_CFG_MCT_LO 3
`define EBC_CFG_MCT_HI 6
`define EBC_CFG_TRI_BIT 7
`define EBC_CFG_ALE_BIT 8
`define EBC_CFG_RWD_BIT 9
`define EBC_CFG_EN_BIT 10
// Window select layout: base [15:4], size code [3:0]
`define EBC_SEL_SIZE_LO 0
`define EBC_SEL_SIZE_HI 3
`define EBC_SEL_BASE_LO 4
`define EBC_SEL_BASE_HI 15
// Reset values
`define EBC_DEFAULT_CFG_RST 16'h0000
`define EBC_WIN_CFG_RST 16'h0000
`define EBC_WIN_SEL_RST 16'h0000
// Fixed phase lengths in cycles
`define EBC_ALE_BASE 4'h1
`define EBC_TRI_BASE 4'h0
`endif

/* ebc_window_match.v */
`timescale 1ns/1ps
`default_nettype none
`include "ebc_map.vh"
// =====================================================================
// Window match: one address window compare
module ebc_window_match (
   // Window definition
   input wire enable,
   input wire [15:0] window_address_select,
   // Address under test
   input wire [21:0] addr,
   // Result
   output reg hit
);
   wire [3:0] size_code;
   wire [11:0] base;
   reg [11:0] mask;
   integer i;
   assign size_code = window_address_select[`EBC_SEL_SIZE_HI:`EBC_SEL_SIZE_LO];
   assign base = window_address_select[`EBC_SEL_BASE_HI:`EBC_SEL_BASE_LO];
   always @* begin
      // Window covers 1 KB << size_code; compare the upper 12 bits
      for (i = 0; i < 12; i = i + 1) begin
         mask[i] = (i >= size_code) ? 1'b1 : 1'b0;
      end
      hit = enable & (((addr[21:10] ^ base) & mask) == 12'h000);
   end
endmodule // ebc_window_match
`default_nettype wire

/* ebc_external_bus_ctrl_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Bus cycle checker
module ebc_chk (
   // Clock and configuration
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [2:0] global_mode,
   input wire logic [1:0] addr_width,
   input wire logic can_on_segment_port,
   // Watched outputs
   input wire logic req_ready,
   input wire logic [5:0] segment_address_oe,
   input wire logic [15:0] shared_data_port_oe,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [3:0] cs_n,
   input wire logic busy
);
   wire logic [5:0] seg_mask;
   assign seg_mask = (addr_width == 2'h3 ? 6'h3f : addr_width == 2'h2 ?
      6'h0f : {4'h0, {2{addr_width == 2'h1}}}) &
      (can_on_segment_port ? 6'h0f : 6'h3f);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_take; $rose(busy); endsequence
   sequence s_strobe; !rd_n || !wr_n; endsequence
   property p_single; global_mode == 3'h0 && !busy |=> !busy; endproperty
   a_single: assert property (p_single)
      else $error("cycle started in single-chip mode");
   property p_excl; !(!rd_n && !wr_n); endproperty
   a_excl: assert property (p_excl)
      else $error("read and write strobes together");
   property p_read; !rd_n |-> shared_data_port_oe == 16'h0; endproperty
   a_read: assert property (p_read)
      else $error("data port driven during read");
   property p_write; !wr_n |-> shared_data_port_oe != 16'h0; endproperty
   a_write: assert property (p_write)
      else $error("data port not driven during write");
   property p_ale; $fell(rd_n) || $fell(wr_n) |-> !ale && busy; endproperty
   a_ale: assert property (p_ale)
      else $error("strobe while address latch open");
   property p_done; s_take |-> ##[5:40] req_ready; endproperty
   a_done: assert property (p_done)
      else $error("bus cycle did not complete");
   property p_gap; req_ready |=> !busy; endproperty
   a_gap: assert property (p_gap)
      else $error("request taken again at handshake end");
   property p_cs; s_strobe |-> $onehot0(~cs_n); endproperty
   a_cs: assert property (p_cs)
      else $error("more than one chip select active");
   property p_seg;
      s_strobe |-> (segment_address_oe & ~seg_mask) == 6'h0;
   endproperty
   a_seg: assert property (p_seg)
      else $error("segment line enabled beyond space");
endmodule // ebc_chk
`default_nettype wire

/* ebc_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================
// External memory on the bus
module ebc_mem (
   // Bus pins
   input wire logic clk_sys,
   input wire logic [2:0] mode,
   input wire logic [15:0] demux_address_port,
   input wire logic [15:0] bus_level,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   output logic [15:0] drive
);
   logic [15:0] mem [0:255];
   logic [15:0] latch = 16'h0;
   logic [15:0] last = 16'h0;
   wire logic mux = mode == 3'h2 || mode == 3'h3;
   wire logic [7:0] idx = mux ? latch[7:0] : demux_address_port[7:0];
   always @(posedge clk_sys) begin
      if (ale && mux) latch <= bus_level;
      if (!wr_n) mem[idx] <= bus_level;
      if (!rd_n) last <= drive;
   end
   // Released bus shows the inverse of the last value
   assign drive = !rd_n ? mem[idx] : ~last;
endmodule // ebc_mem
`default_nettype wire

/* ebc_external_bus_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Bench
module ebc_external_bus_ctrl_tb;
   logic clk_sys = 0, rst = 1, rv = 0, rw = 0, rb = 0, uc = 0, can = 0;
   logic rdy, rsv, ale, rd_n, wr_n, busy;
   logic [2:0] gm = 3'h0;
   logic [1:0] aw = 2'h3;
   logic [15:0] dcfg = 16'h0, wd = 16'h0, rdat, dp, dout, doe, pin, bus_w, d;
   logic [63:0] wcfg = 64'h0, wsel = 64'h0;
   logic [21:0] ra = 22'h0, a;
   logic [5:0] sa, soe, mk;
   logic [3:0] cs_n, cs_seen;
   logic [21:0] wa [4] = '{22'h004100, 22'h008100, 22'h008800, 22'h001000};
   logic [3:0] wc [4] = '{4'hd, 4'h7, 4'hb, 4'he};
   logic [15:0] exp_mem [int];
   int error_cnt = 0, n_compared = 0, seed = 19, lat, lat0;
   assign bus_w = (doe & dout) | (~doe & pin);
   initial forever #4 clk_sys = ~clk_sys;
   ebc_external_bus_ctrl DUT (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
      .global_mode(gm), .addr_width(aw), .chip_select_unlatched_cfg(uc),
      .can_on_segment_port(can), .default_bus_config(dcfg),
      .window_bus_config(wcfg), .window_address_select(wsel), .req_valid(rv),
      .req_write(rw), .req_byte(rb), .req_addr(ra), .req_wdata(wd),
      .req_ready(rdy), .rsp_valid(rsv), .rsp_rdata(rdat),
      .demux_address_port(dp), .segment_address(sa), .segment_address_oe(soe),
      .shared_data_port_out(dout), .shared_data_port_oe(doe),
      .shared_data_port_in(bus_w), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
      .cs_n(cs_n), .busy(busy));
   ebc_mem u_mem (.clk_sys(clk_sys), .mode(dcfg[2:0]), .demux_address_port(dp),
      .bus_level(bus_w), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .drive(pin));
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task close_out;
      $display("compared %0d mismatched %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task acc(input logic w, input logic [21:0] ad, input logic [15:0] dd);
      @(posedge clk_sys);
      rv <= 1'b1; rw <= w; ra <= ad; wd <= dd;
      lat = 0;
      cs_seen = 4'hf;
      do begin
         @(negedge clk_sys);
         lat++;
         if (!rd_n || !wr_n) cs_seen = cs_n;
      end while (rdy !== 1'b1 && lat < 100);
      if (lat >= 100) begin error_cnt++; close_out; end
      chk(rsv, 1'b1, "rsp_valid");
      @(posedge clk_sys) rv <= 1'b0;
      if (w) exp_mem[ad] = dd;
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys) begin rv <= 1'b1; ra <= 22'h001234; end
      repeat (20) begin @(negedge clk_sys); chk({busy, rdy}, 2'h0, "idle"); end
      @(posedge clk_sys) rv <= 1'b0;
      $display("single-chip test done");
      for (int m = 1; m < 5; m++) begin
         @(posedge clk_sys) begin gm <= 3'(m); dcfg <= {13'h0, 3'(m)}; rb <= m > 2; end
         for (int i = 0; i < 3; i++) begin
            a = 22'($random(seed));
            a[7:0] = 8'(i << 4);
            d = 16'($random(seed));
            acc(1'b1, a, d);
            acc(1'b0, a, 16'h0);
            d = m > 2 ? 16'h00ff : 16'hffff;
            chk(rdat & d, exp_mem[a] & d, "rdata");
         end
      end
      $display("mode test done");
      @(posedge clk_sys) begin gm <= 3'h1; dcfg <= 16'h0001; rb <= 1'b0; end
      for (int k = 0; k < 8; k++) begin
         @(posedge clk_sys) begin aw <= k[1:0]; can <= k[2]; end
         acc(1'b0, a, 16'h0);
         mk = (k[1:0] == 2'h3 ? 6'h3f : k[1:0] == 2'h2 ? 6'h0f :
            k[1:0] == 2'h1 ? 6'h03 : 6'h00) & (k[2] ? 6'h0f : 6'h3f);
         chk(soe, mk, "seg_oe");
         chk(sa & mk, a[21:16] & mk, "seg_addr");
      end
      @(posedge clk_sys) begin aw <= 2'h3; can <= 1'b0; end
      $display("segment test done");
      acc(1'b0, a, 16'h0);
      lat0 = lat;
      @(posedge clk_sys) dcfg <= 16'h03a9;
      acc(1'b0, a, 16'h0);
      chk(lat - lat0, 8, "latency");
      $display("timing test done");
      @(posedge clk_sys) begin
         dcfg <= 16'h0001;
         wcfg <= {4{16'h0401}};
         wsel <= {16'h0200, 16'h0202, 16'h0100, 16'h0102};
      end
      for (int j = 0; j < 4; j++) begin
         acc(1'b0, wa[j], 16'h0);
         chk(cs_seen, wc[j], "cs_n");
      end
      @(posedge clk_sys) begin uc <= 1'b1; ra <= 22'h008100; end
      repeat (3) @(negedge clk_sys);
      chk(cs_n, 4'h7, "cs_unlatched");
      $display("window test done");
      close_out;
   end
endmodule // ebc_external_bus_ctrl_tb
bind ebc_external_bus_ctrl ebc_chk u_chk (.clk_sys(clk_sys), .rst(rst),
   .global_mode(global_mode), .addr_width(addr_width),
   .can_on_segment_port(can_on_segment_port), .req_ready(req_ready),
   .segment_address_oe(segment_address_oe),
   .shared_data_port_oe(shared_data_port_oe), .ale(ale), .rd_n(rd_n),
   .wr_n(wr_n), .cs_n(cs_n), .busy(busy));
`default_nettype wire
